/* File: rtl/pstb_pkg.sv */
package pstb_pkg;
	// command codes of the readings and peaks
	localparam logic [7:0] CMD_VIN = 8'h88;
	localparam logic [7:0] CMD_VOUT = 8'h8B;
	localparam logic [7:0] CMD_IOUT = 8'h8C;
	localparam logic [7:0] CMD_TEMP_EXT = 8'h8D;
	localparam logic [7:0] CMD_TEMP_INT = 8'h8E;
	localparam logic [7:0] CMD_DUTY = 8'h94;
	localparam logic [7:0] CMD_FREQ = 8'h95;
	localparam logic [7:0] CMD_POUT = 8'h96;
	localparam logic [7:0] CMD_IOUT_PEAK = 8'hD7;
	localparam logic [7:0] CMD_VOUT_PEAK = 8'hDD;
	localparam logic [7:0] CMD_VIN_PEAK = 8'hDE;
	localparam logic [7:0] CMD_TEMP_EXT_PEAK = 8'hDF;
	localparam logic [7:0] CMD_TEMP_INT_PEAK = 8'hF4;
	localparam logic [7:0] CMD_CLEAR_PEAKS = 8'hE3;
	// status and fault command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_PAD_STATUS = 8'hE5;
	localparam logic [7:0] CMD_COMMON_STATUS = 8'hEF;
	localparam logic [7:0] CMD_INFO_STATUS = 8'hB6;
	// pad status word field positions
	localparam int PAD_SLAVE_LSB = 14;
	localparam int PAD_ZERO_LSB = 12;
	localparam int PAD_IOUT_INV_BIT = 11;
	localparam int PAD_SYNC_DIS_BIT = 10;
	localparam int PAD_PGOOD_LSB = 8;
	localparam int PAD_RUN_FORCE_LSB = 6;
	localparam int PAD_RUN_PIN_LSB = 4;
	localparam int PAD_GPIO_FORCE_LSB = 2;
	localparam int PAD_GPIO_PIN_LSB = 0;
	// common status byte field positions
	localparam int COM_ALERT_FREE_BIT = 7;
	localparam int COM_NOT_BUSY_BIT = 6;
	localparam int COM_NO_CALC_BIT = 5;
	localparam int COM_STEADY_BIT = 4;
	localparam int COM_NVM_INIT_BIT = 3;
	localparam int COM_ZERO_BIT = 2;
	localparam int COM_SHARE_TO_BIT = 1;
	localparam int COM_WP_BIT = 0;
	// info word and reset values
	localparam int INFO_ECC_BIT = 5;
	localparam logic ECC_RESET = 1'b1;
	localparam logic [15:0] READING_RESET = 16'h0000;
	localparam logic [15:0] PEAK_RESET = 16'h0000;
	localparam logic [15:0] UNKNOWN_READ = 16'hFFFF;
	localparam int NUM_PEAKS = 8;
endpackage

/* File: rtl/pstb_peak_if.sv */
`timescale 1ns/1ps
// carries one reading stream into a peak tracker
interface pstb_peak_if;
	logic [15:0] sample; // newest reading
	logic sampleValid; // reading update strobe
	logic clear; // peak-clear strobe
	logic [15:0] peak; // stored peak
	modport tracker(input sample, input sampleValid, input clear, output peak);
	modport owner(output sample, output sampleValid, output clear, input peak);
endinterface

/* File: rtl/pstb_sync2.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module pstb_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys, // system clock
	input wire logic rstnSync, // synchronised reset, low active
	input wire logic [WIDTH-1:0] din, // asynchronous pin levels
	output logic [WIDTH-1:0] dout // synchronised levels
);
	logic [WIDTH-1:0] metaReg; // first stage, read only by dout

	// two flops, nothing taps the first
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			metaReg <= '0;
			dout <= '0;
		end else begin
			metaReg <= din;
			dout <= metaReg;
		end
	end
endmodule

/* File: rtl/pstb_peak_tracker.sv */
`timescale 1ns/1ps
// holds the largest reading since the last clear
module pstb_peak_tracker #(
	parameter bit IS_L11 = 1'b1
) (
	input wire logic clk_sys, // system clock
	input wire logic rstnSync, // synchronised reset, low active
	pstb_peak_if.tracker pk // reading in, peak out
);
	logic [15:0] peakReg; // stored peak
	logic haveReg; // a sample arrived since clear
	logic larger; // new sample beats the peak

	// bring a linear value to one signed scale; unsigned words compare as is
	function automatic logic signed [47:0] scaleOf(input logic [15:0] x);
		logic signed [47:0] m;
		m = 48'(signed'(x[10:0]));
		if (IS_L11)
			scaleOf = m <<< (32'(signed'(x[15:11])) + 16);
		else
			scaleOf = signed'({32'h0000_0000, x});
	endfunction

	assign larger = !haveReg || (scaleOf(pk.sample) > scaleOf(peakReg));
	assign pk.peak = peakReg;

	// R21: track the maximum
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			peakReg <= pstb_pkg::PEAK_RESET;
			haveReg <= 1'b0;
		end else if (pk.sampleValid && (pk.clear || larger)) begin
			// a sample in the clear cycle starts the new peak, not lost
			peakReg <= pk.sample;
			haveReg <= 1'b1;
		end else if (pk.clear) begin
			peakReg <= pstb_pkg::PEAK_RESET;
			haveReg <= 1'b0;
		end
	end

	a_peak_follows: assert property (@(posedge clk_sys) disable iff (!rstnSync) // R21
		pk.sampleValid && !pk.clear && larger |=> pk.peak == $past(pk.sample))
		else $error("peak did not take a larger sample");
	a_peak_holds: assert property (@(posedge clk_sys) disable iff (!rstnSync) // R21
		!pk.sampleValid && !pk.clear |=> $stable(pk.peak))
		else $error("peak changed without a sample");
endmodule

/* File: rtl/pstb_bank.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: pad word bits 15,14 slave flags, 13:12 zero
// R2: pad bits 9,8 give channel power good
// R3: pad bit 11 current invalid, 10 sync disabled
// R4: pad bits 7..4 run forcing and levels
// R5: pad bits 3..0 fault pin forcing, levels
// R6: common bits 7..4 alert, busy, calc, transition
// R7: common bits 3..0 init, zero, timeout, protect
// R8: info bit 5 ECC status, rest zero
// R9: ECC bit refreshed on restore, reset, bulk
// R10: clear-faults clears all bits, releases alert
// R11: clear-faults never restarts a latched channel
// R12: latched channel restarts on off-on or reset
// R13: persisting fault sets again, alert again
// R14: clear-faults carries no data bytes
// R15: input voltage and peak, unpaged linear words
// R16: output voltage and peak, paged unsigned words
// R17: paged output current and its peak
// R18: paged power from correlated voltage, current
// R19: external temp paged, internal unpaged, peaks
// R20: paged duty cycle and frequency readings
// R21: peaks hold largest value since clear
// R22: peak-clear command resets all peaks
// R23: page picks channel for paged readings
module pstb_bank #(
	parameter int NUM_FAULTS = 8,
	parameter logic signed [7:0] VOUT_EXP = -8'sd12
) (
	input wire logic clk_sys, // 40 MHz system clock
	input wire logic rstn, // power-on reset, low active
	input wire logic cmdValid, // command strobe from the bus engine
	input wire logic [7:0] cmdCode, // command code
	input wire logic cmdWrite, // write, else read
	input wire logic cmdHasData, // write carried data bytes
	input wire logic pageSel, // selected channel
	output logic [15:0] rdData, // read answer
	output logic rdAck, // read answer valid pulse
	output logic rdUnknown, // read code not held here
	input wire logic [15:0] vinData, // input voltage sample
	input wire logic vinValid, // input voltage strobe
	input wire logic [15:0] tempIntData, // internal temperature
	input wire logic tempIntValid, // internal temperature strobe
	input wire logic [1:0][15:0] voutData, // output voltage per channel
	input wire logic [1:0] voutValid, // output voltage strobes
	input wire logic [1:0][15:0] ioutData, // output current per channel
	input wire logic [1:0] ioutValid, // output current strobes
	input wire logic [1:0][15:0] tempExtData, // external temperature
	input wire logic [1:0] tempExtValid, // external temperature strobes
	input wire logic [1:0][15:0] dutyData, // commanded duty cycle
	input wire logic [1:0] dutyValid, // duty strobes
	input wire logic [1:0][15:0] freqData, // loop input frequency
	input wire logic [1:0] freqValid, // frequency strobes
	input wire logic [1:0] chSlave, // channel configured as slave
	input wire logic [1:0] chPowerGood, // channel power good
	input wire logic ioutAdcInvalid, // current results may be bad
	input wire logic syncOutDisabled, // sync output disabled outside
	input wire logic [1:0] runForceLow, // device pulls run pins
	input wire logic channel0RunPin, // run pin of channel 0
	input wire logic channel1RunPin, // run pin of channel 1
	input wire logic [1:0] faultForceLow, // device pulls fault pins
	input wire logic faultPin0, // fault pin 0 level
	input wire logic faultPin1, // fault pin 1 level
	input wire logic notBusy, // device idle
	input wire logic calcIdle, // no calculations pending
	input wire logic outputSteady, // output not in transition
	input wire logic nvmInitDone, // memory initialised
	input wire logic sharedClockTimeout, // shared timing clock timeout
	input wire logic wpPin, // write-protect pin level
	input wire logic eccNoCorrections, // memory ECC found nothing
	input wire logic restoreAllDone, // restore-all finished pulse
	input wire logic resetCmdDone, // reset command pulse
	input wire logic nvmBulkReadDone, // bulk read finished pulse
	input wire logic [NUM_FAULTS-1:0] faultCond, // live fault conditions
	input wire logic [1:0] latchFault, // fault latches channel off
	input wire logic [1:0] operationOn, // operation command on level
	output logic alertOut, // alert pin output level
	output logic alertOe, // alert pin pull-down enable
	output logic [NUM_FAULTS-1:0] faultBits, // sticky fault bits
	output logic [1:0] latchedOff, // channel latched off
	output logic [1:0] chanEnable // channel allowed to run
);
	logic [1:0] rstSyncReg; // reset release pipeline
	logic rstnSync; // released reset used everywhere
	logic [4:0] pinSync; // synchronised pin levels
	logic [1:0] runLevel; // run pins, synchronised
	logic [1:0] faultLevel; // fault pins, synchronised
	logic wpLevel; // write-protect, synchronised
	logic takeRead; // read taken this cycle
	logic clearFaults; // accepted clear-faults
	logic peakClear; // accepted peak-clear
	logic [15:0] rdNext; // read mux output
	logic rdKnown; // read code decoded
	logic [15:0] padWord; // assembled pad status
	logic [7:0] commonByte; // assembled common status
	logic [15:0] infoWord; // assembled info status
	logic eccReg; // ECC status bit
	logic porPendReg; // first cycle after reset release
	logic [1:0] onReqReg; // last on request
	logic [1:0] onReq; // on request now
	logic [1:0] onRise; // off-to-on command
	logic [15:0] vinReg; // input voltage reading
	logic [15:0] tempIntReg; // internal temperature reading
	logic [1:0][15:0] voutReg; // output voltage readings
	logic [1:0][15:0] ioutReg; // output current readings
	logic [1:0][15:0] tempExtReg; // external temperature readings
	logic [1:0][15:0] dutyReg; // duty readings
	logic [1:0][15:0] freqReg; // frequency readings
	logic [1:0][15:0] poutReg; // power readings
	logic [15:0] pkSample [pstb_pkg::NUM_PEAKS]; // peak inputs
	logic pkValid [pstb_pkg::NUM_PEAKS]; // peak strobes
	logic [15:0] pkPeak [pstb_pkg::NUM_PEAKS]; // peak outputs

	// assert at once, release after two edges
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			rstSyncReg <= 2'h0;
		else
			rstSyncReg <= {rstSyncReg[0], 1'b1};
	end
	assign rstnSync = rstSyncReg[1];

	// pins come from outside the clock domain
	pstb_sync2 #(.WIDTH(5)) u_pins (
		.clk_sys(clk_sys),
		.rstnSync(rstnSync),
		.din({wpPin, faultPin1, faultPin0, channel1RunPin, channel0RunPin}),
		.dout(pinSync)
	);
	assign runLevel = pinSync[1:0];
	assign faultLevel = pinSync[3:2];
	assign wpLevel = pinSync[4];

	// command decode
	assign takeRead = cmdValid && !cmdWrite;
	// R14: clear-faults only as a write without data
	assign clearFaults = cmdValid && cmdWrite && !cmdHasData && (cmdCode == pstb_pkg::CMD_CLEAR_FAULTS);
	// R22: peak-clear is a send byte, page ignored
	assign peakClear = cmdValid && cmdWrite && !cmdHasData && (cmdCode == pstb_pkg::CMD_CLEAR_PEAKS);

	// power from mantissa product, renormalised to 11 bits
	function automatic logic [15:0] powerOf(input logic [15:0] v, input logic [15:0] i);
		logic signed [27:0] p;
		logic signed [7:0] e;
		p = $signed({1'b0, v}) * $signed(i[10:0]);
		e = 8'(signed'(i[15:11])) + VOUT_EXP;
		for (int k = 0; k < 17; k++) begin
			if (p > 28'sd1023 || p < -28'sd1024) begin
				p = p >>> 1;
				e = e + 8'sd1;
			end
		end
		// exponent clamps to 15 or -16 without rescaling the mantissa; sign kept
		if (e > 8'sd15)
			e = 8'sd15;
		if (e < -8'sd16)
			e = -8'sd16;
		powerOf = {e[4:0], p[10:0]};
	endfunction

	// R15: unpaged input voltage and internal temperature
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			vinReg <= pstb_pkg::READING_RESET;
			tempIntReg <= pstb_pkg::READING_RESET;
		end else begin
			if (vinValid)
				vinReg <= vinData;
			if (tempIntValid)
				tempIntReg <= tempIntData;
		end
	end

	// paged readings, one slot per channel
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			voutReg <= '0;
			ioutReg <= '0;
			tempExtReg <= '0;
			dutyReg <= '0;
			freqReg <= '0;
			poutReg <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				// R16: output voltage word per channel
				if (voutValid[c])
					voutReg[c] <= voutData[c];
				// R17: current arrives already compensated
				if (ioutValid[c])
					ioutReg[c] <= ioutData[c];
				// R18: power pairs each current with the voltage stored before it, not one arriving in the same cycle
				if (ioutValid[c])
					poutReg[c] <= powerOf(voutReg[c], ioutData[c]);
				// R19: external temperature per channel
				if (tempExtValid[c])
					tempExtReg[c] <= tempExtData[c];
				// R20: duty and frequency per channel
				if (dutyValid[c])
					dutyReg[c] <= dutyData[c];
				if (freqValid[c])
					freqReg[c] <= freqData[c];
			end
		end
	end

	// peak stream map: vin, internal temp, vout x2, iout x2, ext temp x2
	always_comb begin
		pkSample[0] = vinData;
		pkValid[0] = vinValid;
		pkSample[1] = tempIntData;
		pkValid[1] = tempIntValid;
		for (int c = 0; c < 2; c++) begin
			pkSample[2 + c] = voutData[c];
			pkValid[2 + c] = voutValid[c];
			pkSample[4 + c] = ioutData[c];
			pkValid[4 + c] = ioutValid[c];
			pkSample[6 + c] = tempExtData[c];
			pkValid[6 + c] = tempExtValid[c];
		end
	end

	// one tracker per peak; output voltage peaks compare unsigned
	for (genvar gi = 0; gi < pstb_pkg::NUM_PEAKS; gi++) begin : g_peak
		pstb_peak_if pk ();
		assign pk.sample = pkSample[gi];
		assign pk.sampleValid = pkValid[gi];
		assign pk.clear = peakClear;
		assign pkPeak[gi] = pk.peak;
		pstb_peak_tracker #(.IS_L11(gi < 2 || gi > 3)) u_peak (
			.clk_sys(clk_sys),
			.rstnSync(rstnSync),
			.pk(pk.tracker)
		);
	end

	// R13: a live condition sets its bit even in the clear cycle
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync)
			faultBits <= '0;
		else if (clearFaults)
			// R10: every bit reloaded from the live conditions at once
			faultBits <= faultCond;
		else
			faultBits <= faultBits | faultCond;
	end

	// R10: alert is pulled low while any fault bit stands
	assign alertOut = 1'b0;
	assign alertOe = |faultBits;

	// remember the on request to spot off-to-on
	assign onReq = operationOn & runLevel;
	assign onRise = onReq & ~onReqReg;
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync)
			onReqReg <= 2'h0;
		else
			onReqReg <= onReq;
	end

	// R11: clear-faults has no say here
	// R12: only off-to-on or power-on reset restarts; a new latch wins
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync)
			latchedOff <= 2'h0;
		else
			latchedOff <= latchFault | (latchedOff & ~onRise);
	end
	assign chanEnable = onReq & ~latchedOff;

	// R9: ECC bit refreshed after power-on and memory events
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			eccReg <= pstb_pkg::ECC_RESET;
			porPendReg <= 1'b1;
		end else begin
			porPendReg <= 1'b0;
			if (porPendReg || restoreAllDone || resetCmdDone || nvmBulkReadDone)
				eccReg <= eccNoCorrections;
		end
	end

	// status words assembled from live state
	always_comb begin
		padWord = 16'h0000;
		// R1: slave flags, bits 13:12 stay zero
		padWord[pstb_pkg::PAD_SLAVE_LSB +: 2] = chSlave;
		// R3: current validity and sync disable
		padWord[pstb_pkg::PAD_IOUT_INV_BIT] = ioutAdcInvalid;
		padWord[pstb_pkg::PAD_SYNC_DIS_BIT] = syncOutDisabled;
		// R2: a slave reports good
		padWord[pstb_pkg::PAD_PGOOD_LSB +: 2] = chPowerGood | chSlave;
		// R4: run forcing and run levels
		padWord[pstb_pkg::PAD_RUN_FORCE_LSB +: 2] = runForceLow;
		padWord[pstb_pkg::PAD_RUN_PIN_LSB +: 2] = runLevel;
		// R5: fault pin forcing and levels
		padWord[pstb_pkg::PAD_GPIO_FORCE_LSB +: 2] = faultForceLow;
		padWord[pstb_pkg::PAD_GPIO_PIN_LSB +: 2] = faultLevel;
		commonByte = 8'h00;
		// R6: alert free, idle, no calc, steady
		commonByte[pstb_pkg::COM_ALERT_FREE_BIT] = !alertOe;
		commonByte[pstb_pkg::COM_NOT_BUSY_BIT] = notBusy;
		commonByte[pstb_pkg::COM_NO_CALC_BIT] = calcIdle;
		commonByte[pstb_pkg::COM_STEADY_BIT] = outputSteady;
		// R7: init, timeout, protect; bit 2 zero
		commonByte[pstb_pkg::COM_NVM_INIT_BIT] = nvmInitDone;
		commonByte[pstb_pkg::COM_SHARE_TO_BIT] = sharedClockTimeout;
		commonByte[pstb_pkg::COM_WP_BIT] = wpLevel;
		// R8: only the ECC bit is live
		infoWord = 16'h0000;
		infoWord[pstb_pkg::INFO_ECC_BIT] = eccReg;
	end

	// R23: paged codes index by page, unpaged ignore it
	always_comb begin
		rdKnown = 1'b1;
		case (cmdCode)
			pstb_pkg::CMD_VIN: rdNext = vinReg;
			pstb_pkg::CMD_VIN_PEAK: rdNext = pkPeak[0];
			pstb_pkg::CMD_TEMP_INT: rdNext = tempIntReg;
			pstb_pkg::CMD_TEMP_INT_PEAK: rdNext = pkPeak[1];
			pstb_pkg::CMD_VOUT: rdNext = voutReg[pageSel];
			pstb_pkg::CMD_VOUT_PEAK: rdNext = pkPeak[2 + 32'(pageSel)];
			pstb_pkg::CMD_IOUT: rdNext = ioutReg[pageSel];
			pstb_pkg::CMD_IOUT_PEAK: rdNext = pkPeak[4 + 32'(pageSel)];
			pstb_pkg::CMD_TEMP_EXT: rdNext = tempExtReg[pageSel];
			pstb_pkg::CMD_TEMP_EXT_PEAK: rdNext = pkPeak[6 + 32'(pageSel)];
			pstb_pkg::CMD_DUTY: rdNext = dutyReg[pageSel];
			pstb_pkg::CMD_FREQ: rdNext = freqReg[pageSel];
			pstb_pkg::CMD_POUT: rdNext = poutReg[pageSel];
			pstb_pkg::CMD_PAD_STATUS: rdNext = padWord;
			pstb_pkg::CMD_COMMON_STATUS: rdNext = {8'h00, commonByte};
			pstb_pkg::CMD_INFO_STATUS: rdNext = infoWord;
			default: begin
				// codes owned by other blocks answer all ones
				rdNext = pstb_pkg::UNKNOWN_READ;
				rdKnown = 1'b0;
			end
		endcase
	end

	// read answer registered one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			rdData <= 16'h0000;
			rdAck <= 1'b0;
			rdUnknown <= 1'b0;
		end else begin
			rdAck <= takeRead;
			rdUnknown <= takeRead && !rdKnown;
			if (takeRead)
				rdData <= rdNext;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstnSync);

	a_pad_readback: assert property (takeRead && cmdCode == pstb_pkg::CMD_PAD_STATUS // R1
		|=> rdAck && rdData == {$past(chSlave), 2'h0, $past(ioutAdcInvalid), $past(syncOutDisabled),
		$past(chPowerGood | chSlave), $past(runForceLow), $past(runLevel), $past(faultForceLow), $past(faultLevel)})
		else $error("pad status read wrong");
	a_common_alert: assert property (takeRead && cmdCode == pstb_pkg::CMD_COMMON_STATUS // R6
		|=> rdData[7] == !$past(alertOe) && rdData[15:8] == 8'h00 && rdData[2] == 1'b0)
		else $error("common status alert bit wrong");
	a_ecc_refresh: assert property (restoreAllDone || resetCmdDone || nvmBulkReadDone // R9
		|=> eccReg == $past(eccNoCorrections))
		else $error("ECC status not refreshed");
	a_clear_release: assert property (clearFaults && faultCond == '0 ##1 faultCond == '0 // R10
		|-> faultBits == '0 && !alertOe)
		else $error("clear-faults left a bit or alert");
	a_fault_reassert: assert property (|faultCond |=> alertOe && (faultBits & $past(faultCond)) == $past(faultCond)) // R13
		else $error("live fault lost after clear");
	a_latch_holds: assert property (clearFaults && (latchedOff & ~onRise) != 2'h0 // R11
		|=> (latchedOff & $past(latchedOff & ~onRise)) == $past(latchedOff & ~onRise))
		else $error("clear-faults restarted a channel");
	a_latch_restart: assert property ((onRise & ~latchFault) != 2'h0 // R12
		|=> (latchedOff & $past(onRise & ~latchFault)) == 2'h0)
		else $error("channel not restarted on off-on");
	a_data_clear_ignored: assert property (cmdValid && cmdWrite && cmdHasData // R14
		&& cmdCode == pstb_pkg::CMD_CLEAR_FAULTS |=> faultBits == ($past(faultBits) | $past(faultCond)))
		else $error("clear-faults with data was taken");
	a_peaks_cleared: assert property (peakClear && !vinValid |=> pkPeak[0] == pstb_pkg::PEAK_RESET) // R22
		else $error("peak-clear left the input voltage peak");
	a_paged_read: assert property (takeRead && cmdCode == pstb_pkg::CMD_VOUT // R23
		|=> rdData == $past(voutReg[pageSel]))
		else $error("paged read used the wrong channel");

	c_clear_faults: cover property (|faultBits ##1 clearFaults ##1 faultBits == '0);
	c_peak_clear: cover property (peakClear ##[1:20] vinValid);
	c_restart: cover property (latchedOff[0] ##[1:50] !latchedOff[0]);
	c_power_read: cover property (takeRead && cmdCode == pstb_pkg::CMD_POUT);
endmodule

/* File: tb/pstb_host_model.sv */
`timescale 1ns/1ps
// bus engine stand-in: hands decoded commands to the bank, collects answers
module pstb_host_model (
	input wire logic clk_sys, // system clock
	input wire logic rdAck, // answer strobe
	input wire logic [15:0] rdData, // answer word
	output logic cmdValid, // command strobe
	output logic [7:0] cmdCode, // command code
	output logic cmdWrite, // write or send byte
	output logic cmdHasData, // data bytes present
	output logic pageSel // selected channel
);
	// idle values from time zero
	initial begin
		cmdValid = 1'b0;
		cmdCode = 8'h00;
		cmdWrite = 1'b0;
		cmdHasData = 1'b0;
		pageSel = 1'b0;
	end
	// one command held for exactly one taking edge
	task automatic issue(input logic [7:0] code, input logic wr, input logic hasData, input logic pg);
		@(posedge clk_sys);
		cmdValid <= 1'b1;
		cmdCode <= code;
		cmdWrite <= wr;
		cmdHasData <= hasData;
		pageSel <= pg;
		@(posedge clk_sys);
		cmdValid <= 1'b0;
		// released code lines never keep the last value
		cmdCode <= ~code;
		#1;
	endtask
	task automatic send(input logic [7:0] code);
		issue(code, 1'b1, 1'b0, 1'b0);
	endtask
	// a missing answer strobe yields unknown data, so it can never match
	task automatic read_word(input logic [7:0] code, input logic pg, output logic [15:0] d);
		issue(code, 1'b0, 1'b0, pg);
		d = (rdAck === 1'b1) ? rdData : 16'hXXXX;
	endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0, rstn = 1'b0; // clock and reset
	logic cmdValid, cmdWrite, cmdHasData, pageSel, rdAck, rdUnknown, alertOut, alertOe; // command side
	logic [7:0] cmdCode, faultBits; // code and sticky faults
	logic [15:0] rdData; // read answer
	logic [1:0] latchedOff, chanEnable; // channel state
	logic [15:0] vinData = '0, tempIntData = '0; // unpaged samples
	logic vinValid = 1'b0, tempIntValid = 1'b0; // unpaged strobes
	logic [1:0][15:0] voutData = '0, ioutData = '0, tempExtData = '0, dutyData = '0, freqData = '0; // paged
	logic [1:0] voutValid = '0, ioutValid = '0, tempExtValid = '0, dutyValid = '0, freqValid = '0; // strobes
	logic [1:0] chSlave = 2'h2, chPowerGood = 2'h0, runForceLow = 2'h1, faultForceLow = 2'h2; // pads
	logic [1:0] latchFault = '0, operationOn = 2'h3; // channel control
	logic ioutAdcInvalid = 1'b1, syncOutDisabled = 1'b0, channel0RunPin = 1'b1, channel1RunPin = 1'b0; // pins
	logic faultPin0 = 1'b1, faultPin1 = 1'b0, notBusy = 1'b1, calcIdle = 1'b0, outputSteady = 1'b1; // levels
	logic nvmInitDone = 1'b1, sharedClockTimeout = 1'b1, wpPin = 1'b1, eccNoCorrections = 1'b1; // status
	logic restoreAllDone = 1'b0, resetCmdDone = 1'b0, nvmBulkReadDone = 1'b0; // memory events
	logic [7:0] faultCond = '0; // live faults
	int fails = 0, cmp_count = 0, cycles = 0; // counters
	// code, page, expected word after two sample rounds
	logic [24:0] tbl [20] = '{{8'h88, 1'b0, 16'hD050}, {8'h88, 1'b1, 16'hD050}, {8'hDE, 1'b1, 16'hD0A0},
		{8'h8B, 1'b0, 16'h0800}, {8'h8B, 1'b1, 16'h1800}, {8'hDD, 1'b0, 16'h1000}, {8'hDD, 1'b1, 16'h2000},
		{8'h8C, 1'b0, 16'hD050}, {8'h8C, 1'b1, 16'hD060}, {8'hD7, 1'b0, 16'hD0A0}, {8'hD7, 1'b1, 16'hD0C0},
		{8'h8D, 1'b1, 16'hD060}, {8'hDF, 1'b0, 16'hD0A0}, {8'h8E, 1'b1, 16'hD050}, {8'hF4, 1'b1, 16'hD0A0},
		{8'h94, 1'b1, 16'hD022}, {8'h95, 1'b0, 16'hD011}, {8'h96, 1'b0, 16'hBA80}, {8'h96, 1'b1, 16'hC300},
		{8'h01, 1'b0, 16'hFFFF}};
	logic [7:0] pk [5] = '{8'hD7, 8'hDD, 8'hDE, 8'hDF, 8'hF4}; // peak codes
	pstb_bank i_pstb_bank (.*);
	pstb_host_model i_pstb_host_model (.*);
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// hang guard, far above the roughly 120 cycles the tests need
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] code, input logic pg, input logic [15:0] exp);
		logic [15:0] d;
		i_pstb_host_model.read_word(code, pg, d);
		chk(d, exp);
		chk({15'h0000, rdUnknown}, {15'h0000, code == 8'h01});
	endtask
	// faults, alert enable, run permission and latch packed in one word
	task automatic st_chk(input logic [15:0] exp);
		chk({faultBits, alertOe, alertOut, 2'h0, chanEnable, latchedOff}, exp);
	endtask
	// memory event k refreshes the ECC flag, nothing else does
	task automatic ecc_step(input logic lvl, input int k);
		@(posedge clk_sys);
		eccNoCorrections <= lvl;
		rd_chk(8'hB6, 1'b0, {10'h000, ~lvl, 5'h00});
		@(posedge clk_sys);
		restoreAllDone <= (k == 0);
		resetCmdDone <= (k == 1);
		nvmBulkReadDone <= (k == 2);
		@(posedge clk_sys);
		{restoreAllDone, resetCmdDone, nvmBulkReadDone} <= 3'h0;
		rd_chk(8'hB6, 1'b1, {10'h000, lvl, 5'h00});
	endtask
	task automatic t_status();
		rd_chk(8'hE5, 1'b0, 16'h8A59);
		rd_chk(8'hEF, 1'b1, 16'h00DB);
		rd_chk(8'hB6, 1'b0, 16'h0020);
		ecc_step(1'b0, 0);
		ecc_step(1'b1, 1);
		ecc_step(1'b0, 2);
		$display("status test done");
	endtask
	task automatic t_faults();
		@(posedge clk_sys);
		faultCond <= 8'h05;
		latchFault <= 2'h1;
		@(posedge clk_sys);
		faultCond <= 8'h01;
		latchFault <= 2'h0;
		rd_chk(8'hEF, 1'b0, 16'h005B);
		st_chk(16'h0581);
		i_pstb_host_model.issue(8'h03, 1'b1, 1'b1, 1'b0);
		st_chk(16'h0581);
		i_pstb_host_model.send(8'h03);
		st_chk(16'h0181);
		@(posedge clk_sys);
		faultCond <= 8'h00;
		i_pstb_host_model.send(8'h03);
		st_chk(16'h0001);
		@(posedge clk_sys);
		operationOn <= 2'h2;
		@(posedge clk_sys);
		operationOn <= 2'h3;
		repeat (3) @(posedge clk_sys);
		#1;
		st_chk(16'h0004);
		$display("fault test done");
	endtask
	task automatic t_telemetry();
		@(posedge clk_sys);
		{vinData, tempIntData} <= {16'hD0A0, 16'hD0A0};
		voutData <= {16'h2000, 16'h1000};
		{ioutData, tempExtData} <= {16'hD0C0, 16'hD0A0, 16'hD0C0, 16'hD0A0};
		{dutyData, freqData} <= {16'hD022, 16'hD011, 16'hD022, 16'hD011};
		{vinValid, tempIntValid, voutValid, ioutValid, tempExtValid, dutyValid, freqValid} <= 12'hFFF;
		@(posedge clk_sys);
		{vinData, tempIntData} <= {16'hD050, 16'hD050};
		voutData <= {16'h1800, 16'h0800};
		{ioutData, tempExtData} <= {16'hD060, 16'hD050, 16'hD060, 16'hD050};
		{dutyValid, freqValid} <= 4'h0;
		@(posedge clk_sys);
		{vinValid, tempIntValid, voutValid, ioutValid, tempExtValid} <= 8'h00;
		foreach (tbl[i]) rd_chk(tbl[i][24:17], tbl[i][16], tbl[i][15:0]);
		i_pstb_host_model.send(8'hE3);
		foreach (pk[i]) rd_chk(pk[i], 1'b1, 16'h0000);
		@(posedge clk_sys);
		vinValid <= 1'b1;
		@(posedge clk_sys);
		vinValid <= 1'b0;
		rd_chk(8'hDE, 1'b0, 16'hD050);
		$display("telemetry test done");
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// reset, then give the pin synchronisers time before the first command
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		t_status();
		t_faults();
		t_telemetry();
		finish_test();
	end
endmodule
